/* core/bit_synchronizer.sv */
`default_nettype none

module bit_synchronizer #(
  parameter int unsigned      WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clock,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  if (WIDTH < 1) begin : g_bad_width
    $error("bit_synchronizer needs WIDTH of at least 1");
  end

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_t;

  sync_t state_q;
  sync_t state_d;

  // The first stage feeds only the second stage.
  always_comb begin
    state_d.meta   = din;
    state_d.stable = state_q.meta;
  end

  // Both stages load the idle level of each pin at reset.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= '{meta: RST_VAL, stable: RST_VAL};
    end else begin
      state_q <= state_d;
    end
  end

  assign dout = state_q.stable;

  a_sync_latency: assert property (@(posedge clock) disable iff (!rst_b)
    $past(rst_b, 2) |-> dout == $past(din, 2))
    else $error("synchroniser latency is not two cycles");

endmodule // bit_synchronizer

`default_nettype wire

/* core/irq_status_bank.sv */
`default_nettype none

module irq_status_bank #(
  parameter int unsigned N = 1
) (
  input  wire logic         clock,
  input  wire logic         rst_b,
  input  wire logic [N-1:0] eventIn,
  input  wire logic         maskWrite,
  input  wire logic [N-1:0] maskData,
  input  wire logic         statusRead,
  output logic      [N-1:0] status,
  output logic      [N-1:0] mask,
  output logic              irq
);

  if (N < 1 || N > 8) begin : g_bad_n
    $error("irq_status_bank serves 1 to 8 events");
  end

  typedef struct packed {
    logic [N-1:0] status;
    logic [N-1:0] mask;
    logic         irq;
  } irqState_t;

  irqState_t state_q;
  irqState_t state_d;

  // A read clears the sticky bits; an event in that cycle still sets.
  always_comb begin
    state_d        = state_q;
    state_d.status = (state_q.status & ~{N{statusRead}}) | eventIn;
    if (maskWrite) begin
      state_d.mask = maskData;
    end
    state_d.irq = |(state_d.status & state_d.mask);
  end

  // Registers the bank.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign status = state_q.status;
  assign mask   = state_q.mask;
  assign irq    = state_q.irq;

  a_read_clear: assert property (@(posedge clock) disable iff (!rst_b)
    statusRead && eventIn == '0 |=> status == '0)
    else $error("status read did not clear the sticky bits");

  a_irq_level: assert property (@(posedge clock) disable iff (!rst_b)
    irq == |(status & mask))
    else $error("interrupt output disagrees with status and mask");

endmodule // irq_status_bank

`default_nettype wire

/* core/pport_map.svh */
`ifndef PPORT_MAP_SVH
`define PPORT_MAP_SVH

// ----------------------------------------------------------------
// Register offsets on the host port.
// ----------------------------------------------------------------
`define PP_REG_DATA      3'h0
`define PP_REG_STATUS    3'h1
`define PP_REG_CONTROL   3'h2
`define PP_REG_EPP_ADDR  3'h3
`define PP_REG_EPP_DATA  3'h4
`define PP_REG_CONFIG    3'h5
`define PP_REG_IRQ_STAT  3'h6
`define PP_REG_IRQ_MASK  3'h7

// ----------------------------------------------------------------
// Field positions and reset values.
// ----------------------------------------------------------------
`define PP_CTL_STROBE    0
`define PP_CTL_AUTOLF    1
`define PP_CTL_INIT      2
`define PP_CTL_SELECT    3
`define PP_CTL_DIR       5
`define PP_CTL_RESET     8'h00
`define PP_CFG_ENABLE    0
`define PP_CFG_EPP       1
`define PP_CFG_RESET     8'h00
`define PP_STS_TIMEOUT   0
`define PP_STS_FAULT     3
`define PP_STS_SELECT    4
`define PP_STS_PAPER     5
`define PP_STS_ACK       6
`define PP_STS_NBUSY     7
`define PP_IRQ_ACK       0
`define PP_IRQ_FAULT     1
`define PP_IRQ_PAPER     2
`define PP_IRQ_EPP_DONE  3
`define PP_IRQ_EPP_TMO   4
`define PP_IRQ_COUNT     5
`define PP_SYNC_RESET    13'h1200
`define PP_PIN_BUSY      8
`define PP_PIN_ACK       9
`define PP_PIN_PAPER     10
`define PP_PIN_SELECT    11
`define PP_PIN_FAULT     12
`define PP_PIN_COUNT     13

// ----------------------------------------------------------------
// Timing.
// ----------------------------------------------------------------
`define PP_CLK_PERIOD_NS   10
`define PP_EPP_TIMEOUT_NS  10000
`define PP_EPP_TIMEOUT_CYC (`PP_EPP_TIMEOUT_NS / `PP_CLK_PERIOD_NS)

`endif

/* core/pport_pkg.sv */
`default_nettype none
`include "pport_map.svh"

package pport_pkg;

  localparam int TMR_W = 16;
  typedef logic [TMR_W-1:0] timer_t;

  // Enhanced cycle sequencer, one-hot.
  typedef enum logic [2:0] {
    EPP_IDLE    = 3'h1,
    EPP_STROBE  = 3'h2,
    EPP_RELEASE = 3'h4
  } eppState_t;

  typedef struct packed {
    logic [7:0] dataReg;
    logic [7:0] ctrl;
    logic [7:0] cfg;
    logic [7:0] eppByte;
    logic [7:0] rdData;
    logic [7:0] pdOut;
    eppState_t  eppState;
    timer_t     timer;
    logic       eppWrite;
    logic       eppIsAddr;
    logic       timedOut;
    logic       prevAck;
    logic       prevFault;
    logic       prevPaper;
    logic       strobe_b;
    logic       autoLf_b;
    logic       init_b;
    logic       select_b;
    logic       ctrlOe_b;
    logic       pdOe_b;
    logic       rdyOe_b;
    logic       rdyOut;
  } portState_t;

  localparam portState_t STATE_RST = '{
    dataReg: 8'h00, ctrl: `PP_CTL_RESET, cfg: `PP_CFG_RESET,
    eppByte: 8'h00, rdData: 8'h00, pdOut: 8'h00,
    eppState: EPP_IDLE, timer: '0, eppWrite: 1'b0, eppIsAddr: 1'b0,
    timedOut: 1'b0, prevAck: 1'b1, prevFault: 1'b1, prevPaper: 1'b0,
    strobe_b: 1'b1, autoLf_b: 1'b1, init_b: 1'b0, select_b: 1'b1,
    ctrlOe_b: 1'b1, pdOe_b: 1'b1, rdyOe_b: 1'b1, rdyOut: 1'b0};

endpackage

`default_nettype wire

/* core/printer_port_pin_logic.sv */
// Design decisions made here: strobed register access and the register addresses.
`default_nettype none
`include "pport_map.svh"

module printer_port_pin_logic
  import pport_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = `PP_EPP_TIMEOUT_CYC
) (
  input  wire logic       clock,
  input  wire logic       rst_b,
  input  wire logic [2:0] addr,
  input  wire logic [7:0] wrData,
  input  wire logic       wrStrobe,
  input  wire logic       rdStrobe,
  output logic      [7:0] rdData,
  output logic            irq,
  input  wire logic [7:0] portDataIn,
  output logic      [7:0] portDataOut,
  output logic            portDataOe_b,
  output logic            dataStrobe_b,
  output logic            autoLineFeed_b,
  output logic            initPrinter_b,
  output logic            selectPrinterOut_b,
  output logic            ctrlOe_b,
  input  wire logic       busy,
  input  wire logic       ack_b,
  input  wire logic       paperOut,
  input  wire logic       printerSelectedIn,
  input  wire logic       fault_b,
  output logic            chanReadyOut,
  output logic            chanReadyOe_b
);

  localparam int    IN_W     = `PP_PIN_COUNT;
  localparam timer_t TMR_LAST = timer_t'(TIMEOUT_CYCLES - 1);

  if (TIMEOUT_CYCLES < 1 || TIMEOUT_CYCLES > (2 ** TMR_W)) begin : g_bad
    $error("TIMEOUT_CYCLES does not fit the cycle timer");
  end

  // ----------------------------------------------------------------
  // Decoding shared by the write, read and sequencer logic.
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [2:0] a, input logic [2:0] r);
    hit = (a == r);
  endfunction

  function automatic logic isEppReg(input logic [2:0] a);
    isEppReg = hit(a, `PP_REG_EPP_ADDR) || hit(a, `PP_REG_EPP_DATA);
  endfunction

  portState_t                    state_q;
  portState_t                    state_d;
  logic       [IN_W-1:0]         pinSync;
  logic                          en;
  logic                          eppMode;
  logic                          eppStart;
  logic                          eppActive;
  logic                          strobeOn;
  logic                          gBusy;
  logic                          gAck_b;
  logic                          gPaper;
  logic                          gSel;
  logic                          gFault_b;
  logic       [7:0]              gData;
  logic       [7:0]              statusByte;
  logic                          eppDone;
  logic                          eppTmo;
  logic       [`PP_IRQ_COUNT-1:0] events;
  logic       [`PP_IRQ_COUNT-1:0] irqStatus;
  logic       [`PP_IRQ_COUNT-1:0] irqMask;

  // ----------------------------------------------------------------
  // Pin inputs.
  // ----------------------------------------------------------------

  // Every printer pin and the data lines pass two flip-flops.
  bit_synchronizer #(
    .WIDTH   (IN_W),
    .RST_VAL (`PP_SYNC_RESET)
  ) u_pin_sync (
    .clock (clock),
    .rst_b (rst_b),
    .din   ({fault_b, printerSelectedIn, paperOut, ack_b, busy,
             portDataIn}),
    .dout  (pinSync)
  );

  // A disabled port sees its inputs held at their idle levels.
  assign en       = state_q.cfg[`PP_CFG_ENABLE];
  assign eppMode  = en & state_q.cfg[`PP_CFG_EPP];
  assign gBusy    = en & pinSync[`PP_PIN_BUSY];
  assign gAck_b   = ~en | pinSync[`PP_PIN_ACK];
  assign gPaper   = en & pinSync[`PP_PIN_PAPER];
  assign gSel     = en & pinSync[`PP_PIN_SELECT];
  assign gFault_b = ~en | pinSync[`PP_PIN_FAULT];
  assign gData    = en ? pinSync[7:0] : 8'h00;

  // Status byte as software reads it.
  always_comb begin
    statusByte                  = 8'h00;
    statusByte[`PP_STS_TIMEOUT] = state_q.timedOut;
    statusByte[`PP_STS_FAULT]   = gFault_b;
    statusByte[`PP_STS_SELECT]  = gSel;
    statusByte[`PP_STS_PAPER]   = gPaper;
    statusByte[`PP_STS_ACK]     = gAck_b;
    statusByte[`PP_STS_NBUSY]   = ~gBusy;
  end

  // ----------------------------------------------------------------
  // Event flags and interrupt.
  // ----------------------------------------------------------------

  // Falling acknowledge, falling fault and rising paper out are events.
  always_comb begin
    events                   = '0;
    events[`PP_IRQ_ACK]      = state_q.prevAck & ~gAck_b;
    events[`PP_IRQ_FAULT]    = state_q.prevFault & ~gFault_b;
    events[`PP_IRQ_PAPER]    = ~state_q.prevPaper & gPaper;
    events[`PP_IRQ_EPP_DONE] = eppDone;
    events[`PP_IRQ_EPP_TMO]  = eppTmo;
  end

  irq_status_bank #(
    .N (`PP_IRQ_COUNT)
  ) u_irq (
    .clock      (clock),
    .rst_b      (rst_b),
    .eventIn    (events),
    .maskWrite  (wrStrobe && hit(addr, `PP_REG_IRQ_MASK)),
    .maskData   (wrData[`PP_IRQ_COUNT-1:0]),
    .statusRead (rdStrobe && hit(addr, `PP_REG_IRQ_STAT)),
    .status     (irqStatus),
    .mask       (irqMask),
    .irq        (irq)
  );

  // ----------------------------------------------------------------
  // Next state.
  // ----------------------------------------------------------------
  assign eppStart = eppMode && state_q.eppState == EPP_IDLE &&
                    (wrStrobe || rdStrobe) && isEppReg(addr);

  always_comb begin
    state_d           = state_q;
    eppDone           = 1'b0;
    eppTmo            = 1'b0;
    state_d.rdData    = 8'h00;
    state_d.prevAck   = gAck_b;
    state_d.prevFault = gFault_b;
    state_d.prevPaper = gPaper;
    state_d.rdyOut    = 1'b0;

    // Host writes; a one written to the timeout bit clears it.
    if (wrStrobe) begin
      case (addr)
        `PP_REG_DATA:    state_d.dataReg = wrData;
        `PP_REG_CONTROL: state_d.ctrl = wrData;
        `PP_REG_CONFIG:  state_d.cfg = wrData;
        `PP_REG_STATUS:  state_d.timedOut =
          state_q.timedOut & ~wrData[`PP_STS_TIMEOUT];
        default: ;
      endcase
    end

    // Host reads, answered in the next cycle only.
    if (rdStrobe) begin
      case (addr)
        `PP_REG_DATA:     state_d.rdData =
          state_q.ctrl[`PP_CTL_DIR] ? gData : state_q.dataReg;
        `PP_REG_STATUS:   state_d.rdData = statusByte;
        `PP_REG_CONTROL:  state_d.rdData = state_q.ctrl;
        `PP_REG_EPP_ADDR: state_d.rdData = state_q.eppByte;
        `PP_REG_EPP_DATA: state_d.rdData = state_q.eppByte;
        `PP_REG_CONFIG:   state_d.rdData = state_q.cfg;
        `PP_REG_IRQ_STAT: state_d.rdData = 8'(irqStatus);
        `PP_REG_IRQ_MASK: state_d.rdData = 8'(irqMask);
        default:          state_d.rdData = 8'h00;
      endcase
    end

    // Enhanced cycle: strobe until busy rises, release until it falls.
    case (state_q.eppState)
      EPP_IDLE: ;
      EPP_STROBE: begin
        if (gBusy) begin
          if (!state_q.eppWrite) begin
            state_d.eppByte = gData;
          end
          state_d.eppState = EPP_RELEASE;
          state_d.timer    = '0;
        end else if (state_q.timer == TMR_LAST) begin
          eppTmo           = 1'b1;
          state_d.eppState = EPP_IDLE;
        end else begin
          state_d.timer = state_q.timer + timer_t'(1);
        end
      end
      EPP_RELEASE: begin
        if (!gBusy) begin
          eppDone          = 1'b1;
          state_d.eppState = EPP_IDLE;
        end else if (state_q.timer == TMR_LAST) begin
          eppTmo           = 1'b1;
          state_d.eppState = EPP_IDLE;
        end else begin
          state_d.timer = state_q.timer + timer_t'(1);
        end
      end
      default: state_d.eppState = EPP_IDLE;
    endcase

    // A new cycle starts only from idle; writes while busy are dropped.
    if (eppStart) begin
      state_d.eppWrite  = wrStrobe;
      state_d.eppIsAddr = hit(addr, `PP_REG_EPP_ADDR);
      state_d.eppState  = EPP_STROBE;
      state_d.timer     = '0;
      if (wrStrobe) begin
        state_d.eppByte = wrData;
      end
    end

    // Leaving enhanced mode or disabling abandons the cycle.
    if (!eppMode) begin
      state_d.eppState = EPP_IDLE;
    end

    // A timeout sets the sticky status bit; the set wins over a clear.
    if (eppTmo) begin
      state_d.timedOut = 1'b1;
    end

    // Pin drive from the next register and sequencer values.
    eppActive = state_d.eppState != EPP_IDLE;
    strobeOn  = state_d.eppState == EPP_STROBE;
    if (eppActive) begin
      state_d.strobe_b = ~state_d.eppWrite;
      state_d.autoLf_b = ~(strobeOn & ~state_d.eppIsAddr);
      state_d.select_b = ~(strobeOn & state_d.eppIsAddr);
      state_d.pdOut    = state_d.eppByte;
      state_d.pdOe_b   = ~(en & state_d.eppWrite);
    end else begin
      state_d.strobe_b = ~state_d.ctrl[`PP_CTL_STROBE];
      state_d.autoLf_b = ~state_d.ctrl[`PP_CTL_AUTOLF];
      state_d.select_b = ~state_d.ctrl[`PP_CTL_SELECT];
      state_d.pdOut    = state_d.dataReg;
      // Lines are released when reading or disabled.
      state_d.pdOe_b   = ~(state_d.cfg[`PP_CFG_ENABLE] &
                           ~state_d.ctrl[`PP_CTL_DIR]);
    end
    state_d.init_b   = state_d.ctrl[`PP_CTL_INIT];
    state_d.ctrlOe_b = ~state_d.cfg[`PP_CFG_ENABLE];
    state_d.rdyOe_b  = ~eppActive;
  end

  // ----------------------------------------------------------------
  // State register.
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= STATE_RST;
    end else begin
      state_q <= state_d;
    end
  end

  // Every output comes straight from a flip-flop.
  assign rdData             = state_q.rdData;
  assign portDataOut        = state_q.pdOut;
  assign portDataOe_b       = state_q.pdOe_b;
  assign dataStrobe_b       = state_q.strobe_b;
  assign autoLineFeed_b     = state_q.autoLf_b;
  assign initPrinter_b      = state_q.init_b;
  assign selectPrinterOut_b = state_q.select_b;
  assign ctrlOe_b           = state_q.ctrlOe_b;
  assign chanReadyOut       = state_q.rdyOut;
  assign chanReadyOe_b      = state_q.rdyOe_b;

  // ----------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  a_strobe_pin: assert property (
    wrStrobe && hit(addr, `PP_REG_CONTROL) && state_q.eppState == EPP_IDLE
    |=> dataStrobe_b == !$past(wrData[`PP_CTL_STROBE]))
    else $error("strobe pin is not the inverse of control bit 0");

  a_autolf_pin: assert property (
    wrStrobe && hit(addr, `PP_REG_CONTROL) && state_q.eppState == EPP_IDLE
    |=> autoLineFeed_b == !$past(wrData[`PP_CTL_AUTOLF]))
    else $error("auto feed pin is not the inverse of control bit 1");

  a_init_pin: assert property (
    wrStrobe && hit(addr, `PP_REG_CONTROL)
    |=> initPrinter_b == $past(wrData[`PP_CTL_INIT]))
    else $error("init pin does not follow control bit 2");

  a_select_pin: assert property (
    wrStrobe && hit(addr, `PP_REG_CONTROL) && state_q.eppState == EPP_IDLE
    |=> selectPrinterOut_b == !$past(wrData[`PP_CTL_SELECT]))
    else $error("select pin is not the inverse of control bit 3");

  a_fault_status: assert property (
    rdStrobe && hit(addr, `PP_REG_STATUS)
    |=> rdData[`PP_STS_FAULT] == $past(gFault_b))
    else $error("status bit 3 does not show the fault pin");

  a_data_release: assert property (
    state_q.ctrl[`PP_CTL_DIR] && state_q.eppState == EPP_IDLE &&
    !eppStart && !(wrStrobe && hit(addr, `PP_REG_CONTROL))
    |=> portDataOe_b)
    else $error("data lines driven while port is reading");

  a_disable_float: assert property (
    !en && !(wrStrobe && hit(addr, `PP_REG_CONFIG))
    |=> portDataOe_b && ctrlOe_b && chanReadyOe_b)
    else $error("disabled port still drives a pin");

  a_ready_stretch: assert property (
    eppStart |=> !chanReadyOe_b [*2])
    else $error("ready line not held low at cycle start");

  a_ready_free: assert property (
    state_q.eppState == EPP_IDLE && !eppStart |=> chanReadyOe_b)
    else $error("ready line held low with no cycle running");

  a_ctrl_readback: assert property (
    rdStrobe && hit(addr, `PP_REG_CONTROL) |=> rdData == $past(state_q.ctrl))
    else $error("control register read back is wrong");

endmodule // printer_port_pin_logic

`default_nettype wire

/* verif/printer_model.sv */
`default_nettype none

// ----------------------------------------------------------------
// Line printer on the far end of the cable.
// ----------------------------------------------------------------
module printer_model (
  input  wire logic clock,
  input  wire logic rst_b,
  input  wire logic dataStrobe_b,
  input  wire logic autoLineFeed_b,
  input  wire logic selectPrinterOut_b,
  input  wire logic ctrlOe_b,
  input  wire logic eppMode,
  input  wire logic faultCmd,
  input  wire logic paperCmd,
  output logic      busy,
  output logic      ack_b,
  output logic      paperOut,
  output logic      printerSelectedIn,
  output logic      fault_b
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [2:0] cnt_q;
  logic       prevStb_q;
  logic       eppBusy_q;
  logic       stbLow;

  // Floating control pins are pulled up, so they read as idle.
  assign stbLow = ~ctrlOe_b & ~dataStrobe_b;

  // A strobe edge starts a print cycle; enhanced strobes echo on busy.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 3'h0;
      prevStb_q <= 1'b0;
      eppBusy_q <= 1'b0;
    end else begin
      prevStb_q <= stbLow;
      eppBusy_q <= ~ctrlOe_b & ~(autoLineFeed_b & selectPrinterOut_b);
      if (cnt_q != 3'h0) cnt_q <= cnt_q + 3'h1;
      else if (stbLow & ~prevStb_q & ~eppMode) cnt_q <= 3'h1;
    end
  end

  // Busy covers five clocks; acknowledge pulses low for two clocks from the last of them.
  assign busy = eppMode ? eppBusy_q : (cnt_q inside {[1:5]});
  assign ack_b = ~(cnt_q == 3'h5 || cnt_q == 3'h6);
  assign paperOut = paperCmd;
  assign printerSelectedIn = ~ctrlOe_b & ~selectPrinterOut_b;
  assign fault_b = ~faultCmd;
endmodule // printer_model

`default_nettype wire

/* verif/printer_port_pin_logic_bench.sv */
`default_nettype none
`include "pport_map.svh"

module printer_port_pin_logic_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic       clock, rst_b, wrStrobe, rdStrobe, irq;
  logic       eppMode, faultCmd, paperCmd, portDataOe_b;
  logic       dataStrobe_b, autoLineFeed_b, initPrinter_b, ctrlOe_b;
  logic       selectPrinterOut_b, busy, ack_b, paperOut, fault_b;
  logic       printerSelectedIn, chanReadyOut, chanReadyOe_b;
  logic [2:0] addr;
  logic [7:0] wrData, rdData, portDataOut, lineLevel, got;
  int         failures, tests_run;

  // The printer drives a fixed byte whenever the port lets go.
  assign lineLevel = portDataOe_b ? 8'h3C : portDataOut;

  printer_port_pin_logic #(.TIMEOUT_CYCLES(8)) uut (
    .clock(clock), .rst_b(rst_b), .addr(addr), .wrData(wrData),
    .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
    .irq(irq), .portDataIn(lineLevel), .portDataOut(portDataOut),
    .portDataOe_b(portDataOe_b), .dataStrobe_b(dataStrobe_b),
    .autoLineFeed_b(autoLineFeed_b), .initPrinter_b(initPrinter_b),
    .selectPrinterOut_b(selectPrinterOut_b), .ctrlOe_b(ctrlOe_b),
    .busy(busy), .ack_b(ack_b), .paperOut(paperOut),
    .printerSelectedIn(printerSelectedIn), .fault_b(fault_b),
    .chanReadyOut(chanReadyOut), .chanReadyOe_b(chanReadyOe_b));

  printer_model printer (
    .clock(clock), .rst_b(rst_b), .dataStrobe_b(dataStrobe_b),
    .autoLineFeed_b(autoLineFeed_b),
    .selectPrinterOut_b(selectPrinterOut_b), .ctrlOe_b(ctrlOe_b),
    .eppMode(eppMode), .faultCmd(faultCmd), .paperCmd(paperCmd),
    .busy(busy), .ack_b(ack_b), .paperOut(paperOut),
    .printerSelectedIn(printerSelectedIn), .fault_b(fault_b));

  // ----------------------------------------------------------------
  // Bus access and checking tasks.
  // ----------------------------------------------------------------
  task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(logic [2:0] a, logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wrData <= d;
    wrStrobe <= 1'b1;
    @(posedge clock);
    wrStrobe <= 1'b0;
  endtask

  task automatic rd(logic [2:0] a, output logic [7:0] d);
    @(posedge clock);
    addr <= a;
    rdStrobe <= 1'b1;
    @(posedge clock);
    rdStrobe <= 1'b0;
    #1 d = rdData;
  endtask

  // Waits a bounded time for irq (sel 1) or the ready enable to settle.
  task automatic waitPin(bit sel, logic lvl);
    int n;
    n = 0;
    while ((sel ? irq : chanReadyOe_b) !== lvl && n < 100) begin
      @(posedge clock);
      #1 n++;
    end
    chk("wait", 8'(sel ? irq : chanReadyOe_b), 8'(lvl));
  endtask

  task automatic report_and_stop();
    $display("Checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Free running 100 MHz clock.
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Cuts a hang short well beyond the expected run length.
  initial begin
    #100000;
    failures++;
    report_and_stop();
  end

  // ----------------------------------------------------------------
  // Test sequence.
  // ----------------------------------------------------------------
  initial begin
    {rst_b, wrStrobe, rdStrobe, eppMode, faultCmd, paperCmd} = 6'h00;
    {addr, wrData, failures, tests_run} = '0;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    #1 chk("ctrlOe", 8'(ctrlOe_b), 8'h01);
    chk("dataOe", 8'(portDataOe_b), 8'h01);
    $display("reset test done");
    wr(`PP_REG_CONFIG, 8'h01);
    for (int v = 0; v < 16; v++) begin
      logic [3:0] c;
      c = 4'(v);
      wr(`PP_REG_CONTROL, {4'h0, c});
      @(posedge clock);
      #1 chk("strobe", 8'(dataStrobe_b), 8'(!c[0]));
      chk("autoLf", 8'(autoLineFeed_b), 8'(!c[1]));
      chk("init", 8'(initPrinter_b), 8'(c[2]));
      chk("select", 8'(selectPrinterOut_b), 8'(!c[3]));
    end
    $display("control pin test done");
    faultCmd <= 1'b1;
    paperCmd <= 1'b1;
    repeat (20) @(posedge clock);
    rd(`PP_REG_STATUS, got);
    chk("status", got, 8'hF0);
    chk("irqMasked", 8'(irq), 8'h00);
    faultCmd <= 1'b0;
    paperCmd <= 1'b0;
    repeat (4) @(posedge clock);
    rd(`PP_REG_STATUS, got);
    chk("status", got, 8'hD8);
    $display("status test done");
    wr(`PP_REG_DATA, 8'hA5);
    wr(`PP_REG_CONTROL, 8'h08);
    #1 chk("dataOe", 8'(portDataOe_b), 8'h00);
    chk("dataOut", portDataOut, 8'hA5);
    wr(`PP_REG_CONTROL, 8'h28);
    repeat (4) @(posedge clock);
    #1 chk("dataOe", 8'(portDataOe_b), 8'h01);
    rd(`PP_REG_DATA, got);
    chk("dataIn", got, 8'h3C);
    $display("data line test done");
    rd(`PP_REG_IRQ_STAT, got);
    wr(`PP_REG_IRQ_MASK, 8'h01);
    wr(`PP_REG_CONTROL, 8'h09);
    wr(`PP_REG_CONTROL, 8'h08);
    waitPin(1'b1, 1'b1);
    rd(`PP_REG_IRQ_STAT, got);
    chk("irqStat", got, 8'h01);
    @(posedge clock);
    #1 chk("irqClear", 8'(irq), 8'h00);
    chk("rdIdle", rdData, 8'h00);
    wr(`PP_REG_CONFIG, 8'h00);
    @(posedge clock);
    #1 chk("ctrlOe", 8'(ctrlOe_b), 8'h01);
    chk("dataOe", 8'(portDataOe_b), 8'h01);
    // A fault raised while disabled must not reach the status byte.
    faultCmd <= 1'b1;
    repeat (3) @(posedge clock);
    rd(`PP_REG_STATUS, got);
    chk("gated", got, 8'hC8);
    faultCmd <= 1'b0;
    $display("interrupt and disable test done");
    eppMode <= 1'b1;
    wr(`PP_REG_CONTROL, 8'h00);
    wr(`PP_REG_CONFIG, 8'h03);
    wr(`PP_REG_IRQ_MASK, 8'h08);
    rd(`PP_REG_IRQ_STAT, got);
    wr(`PP_REG_EPP_DATA, 8'h5A);
    @(posedge clock);
    #1 chk("readyOe", 8'(chanReadyOe_b), 8'h00);
    chk("readyOut", 8'(chanReadyOut), 8'h00);
    chk("eppData", portDataOut, 8'h5A);
    waitPin(1'b0, 1'b1);
    chk("eppIrq", 8'(irq), 8'h01);
    rd(`PP_REG_IRQ_STAT, got);
    chk("eppStat", got, 8'h08);
    // Address read cycle: lines released, select line strobes.
    rd(`PP_REG_EPP_ADDR, got);
    #1 chk("eppRdOe", 8'(portDataOe_b), 8'h01);
    chk("eppAddrStb", 8'(selectPrinterOut_b), 8'h00);
    waitPin(1'b0, 1'b1);
    rd(`PP_REG_EPP_ADDR, got);
    chk("eppRead", got, 8'h3C);
    waitPin(1'b0, 1'b1);
    // A printer that never answers busy makes the cycle time out.
    eppMode <= 1'b0;
    rd(`PP_REG_EPP_DATA, got);
    waitPin(1'b0, 1'b1);
    rd(`PP_REG_STATUS, got);
    chk("timeout", got, 8'hC9);
    wr(`PP_REG_STATUS, 8'h01);
    rd(`PP_REG_STATUS, got);
    chk("tmoClear", got, 8'hC8);
    $display("enhanced cycle test done");
    report_and_stop();
  end
endmodule // printer_port_pin_logic_bench

`default_nettype wire
